/* File: logic/chan_seq_pkg.sv */
// Purpose: shared constants and types of the packet channel sequencer
// Assumes: one clock; all times are counts of channel clock cycles
// Notes: one octbyte occupies four cycles on the data lanes
package chan_seq_pkg;
   localparam int DATA_W = 64;
   localparam int ADR_W = 8;
   localparam int CNT_W = 5;
   localparam int DEV_W = 2;
   localparam int TIME_W = 8;
   localparam int LAT_W = 5;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] OCT_LAST_BEAT = 2'h3;
   localparam logic [TIME_W-1:0] ACK_LATENCY = 8'h04;
   localparam logic [TIME_W-1:0] ACK_WINDOW_DELAY = 8'h06;
   localparam logic [TIME_W-1:0] READ_MINUS_ACK = 8'h04;
   localparam logic [TIME_W-1:0] READ_ADDR_OFFSET = 8'h02;
   localparam logic [TIME_W-1:0] WRITE_ADDR_OFFSET = 8'h02;
   localparam logic [TIME_W-1:0] POST_REG_WRITE_GAP = 8'h03;
   localparam logic [TIME_W-1:0] POST_MEM_WRITE_GAP = 8'h02;
   localparam logic [LAT_W-1:0] READ_LATENCY_RST = 5'h08;
   localparam logic [LAT_W-1:0] WRITE_LATENCY_RST = 5'h06;
   localparam int RD_FIELD_LSB = 0;
   localparam int WR_FIELD_LSB = 8;
   localparam logic [ADR_W-1:0] LAT_REG_ADDR = 8'h00;
   localparam logic [15:0] LAT_REG_RST =
      {3'h0, WRITE_LATENCY_RST, 3'h0, READ_LATENCY_RST};
   typedef enum logic [1:0] {
      ACK_NONE = 2'b00,
      ACK_OKAY = 2'b01,
      ACK_NACK = 2'b10
   } ack_t;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } seq_state_t;
endpackage

/* File: logic/chan_if.sv */
// Purpose: packet channel between initiating and responding ends
// Assumes: both ends run on the same clock
// Notes: every signal is driven from a flip-flop of its owner
`timescale 1ns/1ps
interface chan_if import chan_seq_pkg::*; ();
   logic req_valid;
   logic req_write;
   logic req_reg;
   logic req_serial;
   logic [DEV_W-1:0] req_dev;
   logic [ADR_W-1:0] req_addr;
   logic [CNT_W-1:0] req_count;
   logic serial_address_subpacket_valid;
   logic [ADR_W-1:0] serial_address_subpacket;
   logic sctrl_stop;
   logic wvalid;
   logic [DATA_W-1:0] wdata;
   logic ack_valid;
   ack_t ack_code;
   logic rvalid;
   logic [DATA_W-1:0] rdata;
   modport initiator(output req_valid, req_write, req_reg, req_serial,
      req_dev, req_addr, req_count, serial_address_subpacket_valid, serial_address_subpacket, sctrl_stop, wvalid,
      wdata, input ack_valid, ack_code, rvalid, rdata);
   modport responder(input req_valid, req_write, req_reg, req_serial,
      req_dev, req_addr, req_count, serial_address_subpacket_valid, serial_address_subpacket, sctrl_stop, wvalid,
      wdata, output ack_valid, ack_code, rvalid, rdata);
endinterface // chan_if

/* File: logic/chan_initiator.sv */
// Purpose: initiating end; issues requests, streams write data and
//          serial address/control packets, collects read data
// Assumes: write data for a burst sits in the fifo before the command
// Notes: fifo depth must be a power of two
`timescale 1ns/1ps
module wdata_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic push;
   logic pop;
   logic [AW:0] next_level;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr];
   assign next_level = level_o + {AW'(0), push} - {AW'(0), pop};

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level_o <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         level_o <= next_level;
         in_ready_o <= next_level != (AW+1)'(DEPTH);
         out_valid_o <= next_level != '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule // wdata_fifo

module chan_initiator import chan_seq_pkg::*; (
   input wire logic clk_i,
   input wire logic reset_i,
   chan_if.initiator ch,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_write_i,
   input wire logic cmd_reg_i,
   input wire logic cmd_serial_i,
   input wire logic [DEV_W-1:0] cmd_dev_i,
   input wire logic [ADR_W-1:0] cmd_addr_i,
   input wire logic [ADR_W-1:0] cmd_stride_i,
   input wire logic [CNT_W-1:0] cmd_count_i,
   input wire logic [CNT_W-1:0] cmd_stop_i,
   input wire logic wd_valid_i,
   output logic wd_ready_o,
   input wire logic [DATA_W-1:0] wd_data_i,
   output logic rd_valid_o,
   output logic [DATA_W-1:0] rd_data_o,
   output logic done_o,
   output ack_t done_ack_o
);
   seq_state_t state;
   logic [TIME_W-1:0] cnt;
   logic [TIME_W-1:0] gap;
   logic [TIME_W-1:0] ph;
   logic [TIME_W-1:0] rwait;
   logic [TIME_W-1:0] ph_start;
   logic [TIME_W-1:0] stop_cyc;
   logic [DEV_W-1:0] gap_dev;
   logic [ADR_W-1:0] sa;
   logic [ADR_W-1:0] stride;
   logic [5:0] moved;
   logic [5:0] m_next;
   logic [5:0] rx_left;
   logic [5:0] drain;
   logic [5:0] blk;
   logic [1:0] rbeat;
   logic [1:0] off;
   logic ph_run;
   logic rx_on;
   logic take;
   logic nak_now;
   logic fin;
   logic pop;
   logic f_valid;
   logic [DATA_W-1:0] f_data;
   logic [$clog2(FIFO_DEPTH):0] f_level;
   ack_t ack_st;

   function automatic logic [TIME_W-1:0] sched_d(input logic wr);
      return wr ? {3'h0, WRITE_LATENCY_RST} : ACK_LATENCY + READ_MINUS_ACK;
   endfunction

   function automatic logic [TIME_W-1:0] addr_off(input logic wr);
      return wr ? WRITE_ADDR_OFFSET : READ_ADDR_OFFSET;
   endfunction

   // a stop that would land in the acknowledge window is dropped and the
   // full burst runs instead
   always_comb begin
      m_next = {1'b0, cmd_count_i} + 6'h01;
      stop_cyc = sched_d(cmd_write_i) + {1'b0, cmd_stop_i, 2'b00}
         - addr_off(cmd_write_i);
      if (cmd_stop_i != '0 && cmd_stop_i <= cmd_count_i &&
          stop_cyc > ACK_WINDOW_DELAY) begin
         m_next = {1'b0, cmd_stop_i};
      end
   end

   assign take = state == ST_IDLE && cmd_valid_i && cmd_ready_o &&
      (!cmd_write_i || {1'b0, f_level} >= m_next) &&
      (gap == '0 || cmd_dev_i != gap_dev);
   assign nak_now = state == ST_BUSY && cnt == ACK_LATENCY &&
      !(ch.ack_valid && ch.ack_code == ACK_OKAY);
   assign fin = state == ST_BUSY && cnt >= ACK_WINDOW_DELAY && !ph_run &&
      !ch.wvalid && rx_left == '0 && drain == '0;
   // two cycles ahead: ph 0 sits one cycle before the first subpacket
   // slot, and every channel output lands one cycle after it is set
   assign ph_start = sched_d(ch.req_write) - addr_off(ch.req_write)
      - 8'h02;
   assign off = ch.req_write ? WRITE_ADDR_OFFSET[1:0] :
      READ_ADDR_OFFSET[1:0];
   assign blk = ph[7:2];
   assign pop = (ph_run && ph[1:0] == off && blk < moved && ch.req_write)
      || drain != '0;

   wdata_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(wd_valid_i),
      .in_ready_o(wd_ready_o),
      .in_data_i(wd_data_i),
      .out_valid_o(f_valid),
      .out_ready_i(pop),
      .out_data_o(f_data),
      .level_o(f_level)
   );

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         cnt <= '0;
         gap <= '0;
         gap_dev <= '0;
         cmd_ready_o <= 1'b1;
         done_o <= 1'b0;
         done_ack_o <= ACK_NONE;
         ack_st <= ACK_NONE;
         ch.req_valid <= 1'b0;
         ch.req_write <= 1'b0;
         ch.req_reg <= 1'b0;
         ch.req_serial <= 1'b0;
         ch.req_dev <= '0;
         ch.req_addr <= '0;
         ch.req_count <= '0;
      end else begin
         ch.req_valid <= take;
         done_o <= 1'b0;
         if (take) begin
            state <= ST_BUSY;
            cnt <= '0;
            cmd_ready_o <= 1'b0;
            ch.req_write <= cmd_write_i;
            ch.req_reg <= cmd_reg_i;
            ch.req_serial <= cmd_serial_i;
            ch.req_dev <= cmd_dev_i;
            ch.req_addr <= cmd_addr_i;
            ch.req_count <= cmd_count_i;
         end else if (state == ST_BUSY) begin
            cnt <= cnt + 8'h01;
         end
         if (state == ST_BUSY && cnt == ACK_LATENCY) begin
            ack_st <= ch.ack_valid ? ch.ack_code : ACK_NONE;
         end
         if (fin) begin
            state <= ST_IDLE;
            cmd_ready_o <= 1'b1;
            done_o <= 1'b1;
            done_ack_o <= ack_st;
         end
         if (fin && ch.req_write && ack_st == ACK_OKAY) begin
            gap <= ch.req_reg ? POST_REG_WRITE_GAP : POST_MEM_WRITE_GAP;
            gap_dev <= ch.req_dev;
         end else if (gap != '0) begin
            gap <= gap - 8'h01;
         end
      end
   end

   // ph counts from the cycle before the first subpacket slot; block j
   // carries the address of octbyte j and, for a cut-short burst, the stop after the last one
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ph_run <= 1'b0;
         ph <= '0;
         sa <= '0;
         stride <= '0;
         moved <= '0;
         drain <= '0;
         ch.serial_address_subpacket_valid <= 1'b0;
         ch.serial_address_subpacket <= '0;
         ch.sctrl_stop <= 1'b0;
         ch.wvalid <= 1'b0;
         ch.wdata <= '0;
      end else begin
         ch.sctrl_stop <= 1'b0;
         if (take) begin
            moved <= m_next;
            sa <= cmd_addr_i;
            stride <= cmd_stride_i;
         end
         if (drain != '0) begin
            drain <= drain - 6'h01;
         end
         if (nak_now) begin
            // refused: data already queued is discarded, never driven
            ph_run <= 1'b0;
            ch.serial_address_subpacket_valid <= 1'b0;
            ch.wvalid <= 1'b0;
            drain <= ch.req_write ? moved : 6'h00;
         end else if (state == ST_BUSY && !ph_run && cnt == ph_start) begin
            ph_run <= 1'b1;
            ph <= '0;
         end else if (ph_run) begin
            ph <= ph + 8'h01;
            if (ph[1:0] == 2'b00) begin
               ch.serial_address_subpacket_valid <= ch.req_serial && blk != '0 &&
                  blk < moved;
               if (blk != '0) begin
                  sa <= sa + stride;
                  ch.serial_address_subpacket <= sa + stride;
               end
               ch.sctrl_stop <= blk == moved &&
                  moved != {1'b0, ch.req_count} + 6'h01;
            end
            if (ph[1:0] == off) begin
               if (blk < moved && ch.req_write) begin
                  ch.wvalid <= 1'b1;
                  ch.wdata <= f_data;
               end else begin
                  ch.wvalid <= 1'b0;
               end
               if (blk >= moved) begin
                  ph_run <= 1'b0;
               end
            end
         end
      end
   end

   // read data is located by the acknowledge, not by the data lanes
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rx_on <= 1'b0;
         rx_left <= '0;
         rwait <= '0;
         rbeat <= '0;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
      end else begin
         rd_valid_o <= 1'b0;
         if (take) begin
            rx_left <= cmd_write_i ? 6'h00 : m_next;
         end
         if (nak_now) begin
            rx_left <= '0;
         end else if (state == ST_BUSY && cnt == ACK_LATENCY &&
                      !ch.req_write) begin
            rwait <= READ_MINUS_ACK - 8'h01;
         end else if (rwait != '0) begin
            rwait <= rwait - 8'h01;
            if (rwait == 8'h01) begin
               rx_on <= 1'b1;
               rbeat <= '0;
            end
         end
         if (rx_on) begin
            rbeat <= rbeat + 2'h1;
            if (rbeat == 2'h0) begin
               rd_valid_o <= 1'b1;
               rd_data_o <= ch.rdata;
            end
            if (rbeat == OCT_LAST_BEAT) begin
               rx_left <= rx_left - 6'h01;
               if (rx_left == 6'h01) begin
                  rx_on <= 1'b0;
               end
            end
         end
      end
   end
endmodule // chan_initiator

/* File: logic/chan_responder.sv */
// Purpose: responding end; acknowledges requests, serves memory and
//          latency register, honours serial address and stop packets
// Assumes: subpacket offsets are shorter than one octbyte
// Notes: requests arriving while busy are ignored
`timescale 1ns/1ps
module chan_responder import chan_seq_pkg::*; #(
   parameter logic [DEV_W-1:0] DEVICE_ID = 2'h0
) (
   input wire logic clk_i,
   input wire logic reset_i,
   chan_if.responder ch,
   output logic busy_o,
   output logic [15:0] latency_reg_o
);
   seq_state_t state;
   logic [TIME_W-1:0] cnt;
   logic [TIME_W-1:0] gap;
   logic [TIME_W-1:0] rlat;
   logic [TIME_W-1:0] wlat;
   logic [ADR_W-1:0] addr;
   logic [ADR_W-1:0] serial_address_subpacket_next;
   logic [CNT_W-1:0] left;
   logic [1:0] beat;
   logic okay;
   logic is_wr;
   logic is_reg;
   logic serial;
   logic dphase;
   logic stop_seen;
   logic xfer_done;
   logic take;
   logic dstart;
   logic fin;
   logic [DATA_W-1:0] mem [2**ADR_W];

   function automatic logic [DATA_W-1:0] rd_word(input logic [ADR_W-1:0] a);
      if (!is_reg) begin
         return mem[a];
      end
      return a == LAT_REG_ADDR ?
         {{(DATA_W-16){1'b0}}, latency_reg_o} : '0;
   endfunction

   assign rlat = {3'h0, latency_reg_o[RD_FIELD_LSB +: LAT_W]};
   assign wlat = {3'h0, latency_reg_o[WR_FIELD_LSB +: LAT_W]};
   assign take = state == ST_IDLE && ch.req_valid && ch.req_dev == DEVICE_ID;
   assign dstart = state == ST_BUSY && okay && !dphase && !xfer_done &&
      cnt == (is_wr ? wlat : rlat) - 8'h01;
   // a refused write lingers until the initiator drops its data
   assign fin = state == ST_BUSY && cnt >= ACK_WINDOW_DELAY && xfer_done &&
      !(is_wr && !okay && ch.wvalid);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         cnt <= '0;
         gap <= '0;
         busy_o <= 1'b0;
         okay <= 1'b0;
         is_wr <= 1'b0;
         is_reg <= 1'b0;
         serial <= 1'b0;
         ch.ack_valid <= 1'b0;
         ch.ack_code <= ACK_NONE;
      end else begin
         ch.ack_valid <= 1'b0;
         if (take) begin
            state <= ST_BUSY;
            busy_o <= 1'b1;
            cnt <= 8'h01;
            okay <= gap == '0;
            is_wr <= ch.req_write;
            is_reg <= ch.req_reg;
            serial <= ch.req_serial;
         end else if (state == ST_BUSY) begin
            cnt <= cnt + 8'h01;
         end
         if (state == ST_BUSY && cnt == ACK_LATENCY - 8'h01) begin
            ch.ack_valid <= 1'b1;
            ch.ack_code <= okay ? ACK_OKAY : ACK_NACK;
         end
         if (fin) begin
            state <= ST_IDLE;
            busy_o <= 1'b0;
         end
         // requests too close behind a write are refused, not queued
         if (fin && is_wr && okay) begin
            gap <= is_reg ? POST_REG_WRITE_GAP : POST_MEM_WRITE_GAP;
         end else if (gap != '0) begin
            gap <= gap - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         addr <= '0;
         serial_address_subpacket_next <= '0;
         left <= '0;
         beat <= '0;
         dphase <= 1'b0;
         stop_seen <= 1'b0;
         xfer_done <= 1'b0;
         ch.rvalid <= 1'b0;
         ch.rdata <= '0;
      end else begin
         if (ch.serial_address_subpacket_valid) begin
            serial_address_subpacket_next <= ch.serial_address_subpacket;
         end
         if (take) begin
            addr <= ch.req_addr;
            left <= ch.req_count;
            stop_seen <= 1'b0;
            xfer_done <= gap != '0;
         end
         if ((dphase || dstart) && ch.sctrl_stop) begin
            stop_seen <= 1'b1;
         end
         if (dstart) begin
            dphase <= 1'b1;
            beat <= '0;
            ch.rvalid <= !is_wr;
            ch.rdata <= rd_word(addr);
         end else if (dphase) begin
            beat <= beat + 2'h1;
            if (beat == OCT_LAST_BEAT) begin
               if (left == '0 || stop_seen || ch.sctrl_stop) begin
                  dphase <= 1'b0;
                  xfer_done <= 1'b1;
                  ch.rvalid <= 1'b0;
               end else begin
                  left <= left - 5'h01;
                  addr <= serial ? serial_address_subpacket_next : addr + 8'h01;
                  ch.rdata <= rd_word(serial ? serial_address_subpacket_next : addr + 8'h01);
               end
            end
         end
      end
   end

   // first beat of each write octbyte carries the word
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         latency_reg_o <= LAT_REG_RST;
      end else if (dphase && is_wr && beat == 2'h0 && ch.wvalid && is_reg &&
                   addr == LAT_REG_ADDR) begin
         latency_reg_o <= ch.wdata[15:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (dphase && is_wr && beat == 2'h0 && ch.wvalid && !is_reg) begin
         mem[addr] <= ch.wdata;
      end
   end
endmodule // chan_responder

/* File: verif/chan_seq_assertions.sv */
// Purpose: timing checks on the channel between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the interface signals
`timescale 1ns/1ps
module chan_seq_assertions import chan_seq_pkg::*; #(
   parameter logic [DEV_W-1:0] RESP_ID = 2'h0
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [DEV_W-1:0] req_dev,
   input wire logic ack_valid,
   input wire ack_t ack_code,
   input wire logic rvalid,
   input wire logic wvalid,
   input wire logic serial_address_subpacket_valid,
   input wire logic sctrl_stop
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // cycles since the last request, saturating so old traffic cannot alias
   logic [3:0] since_req;
   always_ff @(posedge clk_i) begin
      if (reset_i)
         since_req <= 4'hF;
      else if (req_valid)
         since_req <= 4'h0;
      else if (since_req != 4'hF)
         since_req <= since_req + 4'h1;
   end
   a_ack_after_req: assert property (ack_valid |-> $past(req_valid, 4))
      else $error("acknowledge not four cycles after request");
   a_read_data_lat: assert property (ack_valid && ack_code == ACK_OKAY &&
      !req_write |-> ##4 $rose(rvalid))
      else $error("read data not four cycles after okay");
   a_octbyte_hold: assert property ($rose(rvalid) |-> rvalid [*4])
      else $error("read octbyte shorter than four cycles");
   a_write_data_lat: assert property ($rose(wvalid) |-> $past(req_valid, 6)
      && $past(req_write, 6) ##1 wvalid [*3])
      else $error("write data not at write latency");
   a_absent_no_data: assert property (req_valid && req_dev != RESP_ID |->
      (!ack_valid && !rvalid && !wvalid) [*8])
      else $error("traffic for an absent device");
   a_serial_address_subpacket_leads: assert property ($fell(serial_address_subpacket_valid) |->
      ##2 $fell(rvalid || wvalid))
      else $error("serial address not two cycles ahead of data");
   a_stop_leads: assert property (sctrl_stop |->
      ##2 $fell(rvalid || wvalid))
      else $error("stop not two cycles before data end");
   a_stop_window: assert property (sctrl_stop |-> since_req >= 4'h6)
      else $error("stop inside acknowledge window");
   c_okay_read: cover property (ack_valid && ack_code == ACK_OKAY && !req_write);
   c_okay_write: cover property (ack_valid && ack_code == ACK_OKAY && req_write);
   c_stop: cover property (sctrl_stop);
   c_absent: cover property (req_valid && req_dev != RESP_ID);
endmodule // chan_seq_assertions

/* File: verif/channel_transaction_sequencer_tb.sv */
// Purpose: drives the initiating end from the user side and scores results
// Assumes: responder is device 0; device 1 is absent
// Notes: expected data comes from a memory model kept in the bench
`timescale 1ns/1ps
`define CHK(g, e) check(64'(g), 64'(e))
module channel_transaction_sequencer_tb import chan_seq_pkg::*;;
   logic clk_i, reset_i, cmd_valid_i, cmd_write_i, cmd_reg_i, cmd_serial_i;
   logic [DEV_W-1:0] cmd_dev_i;
   logic [ADR_W-1:0] cmd_addr_i, cmd_stride_i;
   logic [CNT_W-1:0] cmd_count_i, cmd_stop_i;
   logic wd_valid_i, cmd_ready_o, wd_ready_o, rd_valid_o, done_o, busy_o;
   logic [DATA_W-1:0] wd_data_i, rd_data_o;
   logic [15:0] latency_reg_o;
   ack_t done_ack_o;
   int n_errors, checks_done;
   logic [31:0] seed;
   logic [63:0] mem [256];
   logic [63:0] exp_rd [$];
   ack_t exp_ack [$];
   chan_if i_chan_if ();
   chan_initiator i_chan_initiator (.clk_i(clk_i), .reset_i(reset_i),
      .ch(i_chan_if), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .cmd_write_i(cmd_write_i), .cmd_reg_i(cmd_reg_i),
      .cmd_serial_i(cmd_serial_i), .cmd_dev_i(cmd_dev_i),
      .cmd_addr_i(cmd_addr_i), .cmd_stride_i(cmd_stride_i),
      .cmd_count_i(cmd_count_i), .cmd_stop_i(cmd_stop_i),
      .wd_valid_i(wd_valid_i), .wd_ready_o(wd_ready_o),
      .wd_data_i(wd_data_i), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .done_o(done_o), .done_ack_o(done_ack_o));
   chan_responder #(.DEVICE_ID(2'h0)) i_chan_responder (.clk_i(clk_i),
      .reset_i(reset_i), .ch(i_chan_if), .busy_o(busy_o),
      .latency_reg_o(latency_reg_o));
   chan_seq_assertions #(.RESP_ID(2'h0)) i_chan_seq_assertions (
      .clk_i(clk_i), .reset_i(reset_i), .req_valid(i_chan_if.req_valid),
      .req_write(i_chan_if.req_write), .req_dev(i_chan_if.req_dev),
      .ack_valid(i_chan_if.ack_valid), .ack_code(i_chan_if.ack_code),
      .rvalid(i_chan_if.rvalid), .wvalid(i_chan_if.wvalid),
      .serial_address_subpacket_valid(i_chan_if.serial_address_subpacket_valid), .sctrl_stop(i_chan_if.sctrl_stop));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic check(input logic [63:0] g, input logic [63:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one transaction: load fifo, note expectations, issue, wait for done
   task automatic op(input logic w, rg, input logic [1:0] dv,
      input logic [7:0] a, s, input logic [4:0] c, p, input ack_t ak);
      int n;
      logic [7:0] ad;
      logic [63:0] d;
      n = (p != 0) ? p : c + 1;
      for (int j = 0; j < n; j++) begin
         ad = a + 8'(j * s);
         if (w) begin
            d = {rnd(), rnd()};
            @(negedge clk_i);
            wd_valid_i = 1'b1;
            wd_data_i = d;
            while (!wd_ready_o) @(negedge clk_i);
            @(posedge clk_i);
            if (ak == ACK_OKAY && !rg)
               mem[ad] = d;
         end else if (ak == ACK_OKAY)
            exp_rd.push_back(rg ? (a == 8'h00 ? 64'(LAT_REG_RST) : 64'h0)
               : mem[ad]);
      end
      exp_ack.push_back(ak);
      @(negedge clk_i);
      wd_valid_i = 1'b0;
      if (w && n == FIFO_DEPTH)
         `CHK(wd_ready_o, 1'b0);
      // unit stride runs without serial address packets
      {cmd_write_i, cmd_reg_i, cmd_serial_i} = {w, rg, !rg && s != 8'h01};
      {cmd_dev_i, cmd_addr_i, cmd_stride_i} = {dv, a, s};
      {cmd_count_i, cmd_stop_i, cmd_valid_i} = {c, p, 1'b1};
      do @(negedge clk_i); while (!i_chan_if.req_valid);
      cmd_valid_i = 1'b0;
      do @(negedge clk_i); while (!done_o);
   endtask
   always @(negedge clk_i) begin
      if (!reset_i && rd_valid_o)
         `CHK(rd_data_o, exp_rd.size() ? exp_rd.pop_front() : 'x);
      if (!reset_i && done_o)
         `CHK(done_ack_o, exp_ack.size() ? exp_ack.pop_front() : 'x);
   end
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (10000) @(posedge clk_i);
      n_errors++;
      complete_run();
   end
   initial begin
      logic [7:0] a, s;
      logic [4:0] c, pw, pr;
      {reset_i, cmd_valid_i, cmd_write_i, cmd_reg_i, cmd_serial_i} = 5'h10;
      {cmd_dev_i, cmd_addr_i, cmd_stride_i, cmd_count_i, cmd_stop_i} = '0;
      {wd_valid_i, wd_data_i} = '0;
      {n_errors, checks_done} = '0;
      seed = 32'h1FE28BDE;
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      `CHK(latency_reg_o, LAT_REG_RST);
      `CHK(cmd_ready_o, 1'b1);
      op(0, 1, 0, 8'h00, 8'h00, 0, 0, ACK_OKAY);
      op(1, 1, 0, 8'h05, 8'h00, 0, 0, ACK_OKAY);
      op(0, 1, 0, 8'h05, 8'h00, 0, 0, ACK_OKAY);
      op(0, 0, 1, 8'h10, 8'h01, 1, 0, ACK_NONE);
      op(1, 0, 1, 8'h10, 8'h01, 1, 0, ACK_NONE);
      for (int i = 0; i < 6; i++) begin
         a = 8'(rnd());
         s = 8'(rnd());
         c = 5'(rnd() % 4);
         pw = c ? 5'(rnd() % (c + 1)) : 5'h00;
         pr = pw ? pw : (c ? 5'(rnd() % (c + 1)) : 5'h00);
         op(1, 0, 0, a, s, c, pw, ACK_OKAY);
         op(0, 0, 0, a, s, c, pr, ACK_OKAY);
      end
      op(1, 0, 0, 8'h40, 8'h01, 15, 0, ACK_OKAY);
      op(0, 0, 0, 8'h40, 8'h01, 15, 0, ACK_OKAY);
      repeat (4) @(posedge clk_i);
      `CHK(exp_rd.size() + exp_ack.size(), 0);
      complete_run();
   end
endmodule // channel_transaction_sequencer_tb
